// file: sdo_pkg.sv
/*
  Shared constants, types and carriers of the SDO request handshake block.
  Assumes a single 250 MHz clock domain.
*/
package sdo_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int RESP_TIMEOUT_NS = 1000000;
  localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int TMO_W = 20;

  localparam int NUM_SLAVES = 8;
  localparam int NUM_EV = 4;
  localparam int ADDR_W = 8;

  localparam logic [15:0] SLOT_MAX = 16'h000b;
  localparam logic [15:0] WCNT_MIN = 16'h0001;
  localparam logic [15:0] WCNT_MAX = 16'h0008;
  localparam logic [15:0] NODE_MIN = 16'h0001;
  localparam logic [15:0] NODE_MAX = 16'h007f;
  localparam logic [15:0] SVC_READ = 16'h0001;
  localparam logic [15:0] SVC_WRITE = 16'h0002;

  localparam logic [15:0] CODE_IDLE = 16'h0000;
  localparam logic [15:0] CODE_OK = 16'h0001;
  localparam logic [15:0] CODE_TIMEOUT = 16'h0003;
  localparam logic [15:0] CODE_BUSY = 16'h0007;
  localparam logic [15:0] CODE_REMOTE = 16'h000a;
  localparam logic [15:0] CODE_PARAM = 16'h000b;

  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CFG_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 8'h14;
  localparam logic [ADDR_W-1:0] REG_LAST_CODE = 8'h18;

  localparam int CTRL_MANDATORY_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int EV_DONE = 0;
  localparam int EV_ERROR = 1;
  localparam int EV_ABORT = 2;
  localparam int EV_DENIED = 3;

  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [NUM_SLAVES-1:0] CFG_MASK_RST = 8'h00;
  localparam logic [NUM_EV-1:0] IRQ_EN_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_HOLD = 3'b100
  } hs_state_t;

  typedef struct packed {
    logic [15:0] slot;
    logic [15:0] node;
    logic [15:0] service;
    logic [15:0] index;
    logic [15:0] subindex;
    logic [15:0] wcount;
    logic [1:0][31:0] payload;
  } sdo_req_t;

  typedef struct packed {
    logic fail;
    logic [15:0] abort_reason;
    logic [15:0] rcount;
    logic [1:0][31:0] payload;
  } sdo_resp_t;

  typedef struct packed {
    logic [15:0] fail_code;
    logic [15:0] abort_reason;
    logic [15:0] read_byte_count;
    logic [1:0][31:0] read_payload;
  } sdo_result_t;

endpackage

// file: net_cfg_check.sv
/*
  Start-up check of the network configuration and process-data enables.
  Assumes slave status vectors come from link logic on the same clock.
*/
`timescale 1ns/10ps
module net_cfg_check (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic mandatory_i,
  input wire logic start_i,
  input wire logic [sdo_pkg::NUM_SLAVES-1:0] cfg_mask_i,
  input wire logic [sdo_pkg::NUM_SLAVES-1:0] online_i,
  input wire logic [sdo_pkg::NUM_SLAVES-1:0] cfg_ok_i,
  output logic run_o,
  output logic denied_o,
  output logic [sdo_pkg::NUM_SLAVES-1:0] exchange_o
);
  logic run_q, run_d;
  logic passed_q, passed_d;
  logic denied_q, denied_d;
  logic [sdo_pkg::NUM_SLAVES-1:0] good;
  logic all_good;
  logic [sdo_pkg::NUM_SLAVES-1:0] exch_q, exch_d;

  assign good = cfg_mask_i & online_i & cfg_ok_i;
  assign all_good = (good == cfg_mask_i);

  always_comb begin
    run_d = run_q;
    passed_d = passed_q;
    denied_d = 1'b0;
    if (!start_i) begin
      run_d = 1'b0;
    end else if (!run_q) begin
      if (mandatory_i && !passed_q && !all_good) begin
        denied_d = !denied_q;
      end else begin
        run_d = 1'b1;
        passed_d = 1'b1;
      end
    end
    exch_d = run_d ? good : '0;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      run_q <= 1'b0;
      passed_q <= 1'b0;
      denied_q <= 1'b0;
      exch_q <= '0;
    end else if (ce_i) begin
      run_q <= run_d;
      passed_q <= passed_d;
      denied_q <= denied_d;
      exch_q <= exch_d;
    end
  end

  assign run_o = run_q;
  assign denied_o = denied_q;
  // Registered so the mask toward the process-data side is a clean flop output
  assign exchange_o = exch_q;

  a_mandatory_gate: assert property (@(posedge clk_i iff ce_i) disable iff (sys_rst_i)
    mandatory_i && !passed_q && !all_good |=> !run_q)
    else $error("run started with a slave missing");
endmodule

// file: irq_block.sv
/*
  Sticky event status, enable mask and write-one-to-clear, one level interrupt.
  Assumes event pulses and the clear strobe are on the same clock.
*/
`timescale 1ns/10ps
module irq_block (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [sdo_pkg::NUM_EV-1:0] event_i,
  input wire logic en_wr_i,
  input wire logic clr_wr_i,
  input wire logic [sdo_pkg::NUM_EV-1:0] wdata_i,
  output logic [sdo_pkg::NUM_EV-1:0] status_o,
  output logic [sdo_pkg::NUM_EV-1:0] enable_o,
  output logic irq_o
);
  logic [sdo_pkg::NUM_EV-1:0] status_q, status_d;
  logic [sdo_pkg::NUM_EV-1:0] enable_q, enable_d;

  always_comb begin
    enable_d = en_wr_i ? wdata_i : enable_q;
    // A set in the clearing cycle wins so no event is lost
    status_d = (status_q & ~(clr_wr_i ? wdata_i : '0)) | event_i;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      status_q <= '0;
      enable_q <= sdo_pkg::IRQ_EN_RST;
    end else if (ce_i) begin
      status_q <= status_d;
      enable_q <= enable_d;
    end
  end

  assign status_o = status_q;
  assign enable_o = enable_q;
  assign irq_o = |(status_q & enable_q);
endmodule

// file: sdo_request_block.sv
/*
  SDO request handshake: execute edge, parameter capture, forwarding to the
  target node, result outputs, configuration check and a small register port.
  Assumes the controller program, the node link and software all run on clk_i.
*/
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps

module sdo_request_block #(
  parameter int unsigned RESP_TIMEOUT_CYC = sdo_pkg::RESP_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic execute_i,
  input wire sdo_pkg::sdo_req_t req_i,
  input wire logic abort_cmd_i,
  output logic done_o,
  output logic busy_o,
  output logic aborted_o,
  output logic error_o,
  output sdo_pkg::sdo_result_t result_o,
  output logic node_req_valid_o,
  input wire logic node_req_ready_i,
  output sdo_pkg::sdo_req_t node_req_o,
  input wire logic node_resp_valid_i,
  input wire sdo_pkg::sdo_resp_t node_resp_i,
  input wire logic [sdo_pkg::NUM_SLAVES-1:0] slave_online_i,
  input wire logic [sdo_pkg::NUM_SLAVES-1:0] slave_cfg_ok_i,
  output logic master_run_o,
  output logic [sdo_pkg::NUM_SLAVES-1:0] pdo_exchange_o,
  input wire logic [sdo_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o
);
  sdo_pkg::hs_state_t state_q, state_d;
  sdo_pkg::sdo_req_t req_q, req_d;
  sdo_pkg::sdo_result_t res_q, res_d;
  logic exec_prev_q;
  logic rise;
  logic done_q, done_d;
  logic error_q, error_d;
  logic abort_q, abort_d;
  logic sent_q, sent_d;
  logic [sdo_pkg::TMO_W-1:0] tmo_q, tmo_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [sdo_pkg::NUM_SLAVES-1:0] mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic [sdo_pkg::NUM_EV-1:0] ev;
  logic [sdo_pkg::NUM_EV-1:0] irq_status;
  logic [sdo_pkg::NUM_EV-1:0] irq_enable;
  logic denied;
  logic req_bad;

  // Parameters out of range are refused with the parameter code
  function automatic logic param_bad(input sdo_pkg::sdo_req_t r);
    logic bad;
    bad = 1'b0;
    if (r.slot > sdo_pkg::SLOT_MAX) begin
      bad = 1'b1;
    end
    if (r.node < sdo_pkg::NODE_MIN || r.node > sdo_pkg::NODE_MAX) begin
      bad = 1'b1;
    end
    if (r.service != sdo_pkg::SVC_READ && r.service != sdo_pkg::SVC_WRITE) begin
      bad = 1'b1;
    end
    if (r.service == sdo_pkg::SVC_WRITE &&
        (r.wcount < sdo_pkg::WCNT_MIN || r.wcount > sdo_pkg::WCNT_MAX)) begin
      bad = 1'b1;
    end
    return bad;
  endfunction

  assign rise = execute_i && !exec_prev_q;
  assign req_bad = param_bad(req_q);

  always_comb begin
    state_d = state_q;
    req_d = req_q;
    res_d = res_q;
    done_d = done_q;
    error_d = error_q;
    abort_d = abort_q;
    sent_d = sent_q;
    tmo_d = tmo_q;
    unique case (state_q)
      sdo_pkg::ST_IDLE: begin
        if (rise) begin
          req_d = req_i;
          sent_d = 1'b0;
          tmo_d = '0;
          state_d = sdo_pkg::ST_WAIT;
        end
      end
      sdo_pkg::ST_WAIT: begin
        tmo_d = tmo_q + 1'b1;
        if (req_bad) begin
          error_d = 1'b1;
          res_d.fail_code = sdo_pkg::CODE_PARAM;
          res_d.abort_reason = '0;
          state_d = sdo_pkg::ST_HOLD;
        end else if (abort_cmd_i) begin
          abort_d = 1'b1;
          state_d = sdo_pkg::ST_HOLD;
        end else if (!master_run_o) begin
          error_d = 1'b1;
          res_d.fail_code = sdo_pkg::CODE_BUSY;
          res_d.abort_reason = '0;
          state_d = sdo_pkg::ST_HOLD;
        end else if (sent_q && node_resp_valid_i) begin
          state_d = sdo_pkg::ST_HOLD;
          res_d.abort_reason = node_resp_i.abort_reason;
          if (node_resp_i.fail) begin
            error_d = 1'b1;
            res_d.fail_code = sdo_pkg::CODE_REMOTE;
          end else begin
            done_d = 1'b1;
            res_d.fail_code = sdo_pkg::CODE_OK;
            res_d.read_byte_count = node_resp_i.rcount;
            res_d.read_payload = node_resp_i.payload;
          end
        end else if (tmo_q == sdo_pkg::TMO_W'(RESP_TIMEOUT_CYC - 1)) begin
          error_d = 1'b1;
          res_d.fail_code = sdo_pkg::CODE_TIMEOUT;
          res_d.abort_reason = '0;
          state_d = sdo_pkg::ST_HOLD;
        end else if (node_req_valid_o && node_req_ready_i) begin
          sent_d = 1'b1;
        end
      end
      sdo_pkg::ST_HOLD: begin
        if (!execute_i) begin
          done_d = 1'b0;
          error_d = 1'b0;
          abort_d = 1'b0;
          state_d = sdo_pkg::ST_IDLE;
        end
      end
      default: begin
        done_d = 1'b0;
        error_d = 1'b0;
        abort_d = 1'b0;
        state_d = sdo_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= sdo_pkg::ST_IDLE;
      req_q <= '0;
      res_q <= '0;
      done_q <= 1'b0;
      error_q <= 1'b0;
      abort_q <= 1'b0;
      sent_q <= 1'b0;
      tmo_q <= '0;
      exec_prev_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      req_q <= req_d;
      res_q <= res_d;
      done_q <= done_d;
      error_q <= error_d;
      abort_q <= abort_d;
      sent_q <= sent_d;
      tmo_q <= tmo_d;
      exec_prev_q <= execute_i;
    end
  end

  assign done_o = done_q;
  assign error_o = error_q;
  assign aborted_o = abort_q;
  // Busy spans the wait state only
  assign busy_o = (state_q == sdo_pkg::ST_WAIT);
  assign result_o = res_q;
  assign node_req_o = req_q;
  assign node_req_valid_o = busy_o && !sent_q && !req_bad && master_run_o && !abort_cmd_i;

  net_cfg_check u_cfg (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .mandatory_i(ctrl_q[sdo_pkg::CTRL_MANDATORY_BIT]),
    .start_i(ctrl_q[sdo_pkg::CTRL_START_BIT]),
    .cfg_mask_i(mask_q),
    .online_i(slave_online_i),
    .cfg_ok_i(slave_cfg_ok_i),
    .run_o(master_run_o),
    .denied_o(denied),
    .exchange_o(pdo_exchange_o)
  );

  assign ev = {denied, abort_d && !abort_q, error_d && !error_q, done_d && !done_q};

  irq_block u_irq (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .event_i(ev),
    .en_wr_i(reg_wr_i && reg_addr_i == sdo_pkg::REG_IRQ_ENABLE),
    .clr_wr_i(reg_wr_i && reg_addr_i == sdo_pkg::REG_IRQ_CLEAR),
    .wdata_i(reg_wdata_i[sdo_pkg::NUM_EV-1:0]),
    .status_o(irq_status),
    .enable_o(irq_enable),
    .irq_o(irq_o)
  );

  // Register port: writes land at once, reads answer one cycle later
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    rdata_d = '0;
    if (reg_wr_i) begin
      if (reg_addr_i == sdo_pkg::REG_CTRL) begin
        ctrl_d = reg_wdata_i[1:0];
      end
      if (reg_addr_i == sdo_pkg::REG_CFG_MASK) begin
        mask_d = reg_wdata_i[sdo_pkg::NUM_SLAVES-1:0];
      end
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        sdo_pkg::REG_CTRL: rdata_d = {30'h0, ctrl_q};
        sdo_pkg::REG_CFG_MASK: rdata_d = {24'h0, mask_q};
        sdo_pkg::REG_STATE: rdata_d = {16'h0, pdo_exchange_o, 3'h0, master_run_o, busy_o, state_q};
        sdo_pkg::REG_IRQ_STATUS: rdata_d = {28'h0, irq_status};
        sdo_pkg::REG_IRQ_ENABLE: rdata_d = {28'h0, irq_enable};
        sdo_pkg::REG_LAST_CODE: rdata_d = {res_q.abort_reason, res_q.fail_code};
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= sdo_pkg::CTRL_RST;
      mask_q <= sdo_pkg::CFG_MASK_RST;
      rdata_q <= '0;
    end else if (ce_i) begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // Checks are sampled only on enabled edges since ce low freezes state
  a_busy_on_launch: assert property (@(posedge clk_i iff ce_i) disable iff (sys_rst_i)
    rise && state_q == sdo_pkg::ST_IDLE |=> busy_o)
    else $error("busy did not rise on launch");

  a_busy_result_drop: assert property (@(posedge clk_i iff ce_i) disable iff (sys_rst_i)
    $rose(done_o) || $rose(error_o) || $rose(aborted_o) |-> !busy_o && $past(busy_o))
    else $error("busy not dropped with result");

  a_single_result: assert property (@(posedge clk_i iff ce_i) disable iff (sys_rst_i)
    $onehot0({done_o, error_o, aborted_o}))
    else $error("more than one result flag");

  a_ignore_while_busy: assert property (@(posedge clk_i iff ce_i) disable iff (sys_rst_i)
    busy_o && $past(busy_o) |-> $stable(node_req_o))
    else $error("request changed while busy");

  a_done_clear: assert property (@(posedge clk_i iff ce_i) disable iff (sys_rst_i)
    done_o && !execute_i |=> !done_o)
    else $error("done stayed after execute low");

  a_abort_clear: assert property (@(posedge clk_i iff ce_i) disable iff (sys_rst_i)
    aborted_o && !execute_i |=> !aborted_o)
    else $error("aborted stayed after execute low");

  a_error_hold: assert property (@(posedge clk_i iff ce_i) disable iff (sys_rst_i)
    error_o && execute_i |=> error_o || !execute_i)
    else $error("error dropped with execute high");

  a_done_codes: assert property (@(posedge clk_i iff ce_i) disable iff (sys_rst_i)
    $rose(done_o) |-> result_o.fail_code == sdo_pkg::CODE_OK)
    else $error("fail code not updated on done");

  a_read_data: assert property (@(posedge clk_i iff ce_i) disable iff (sys_rst_i)
    busy_o && sent_q && node_resp_valid_i && !node_resp_i.fail && !abort_cmd_i && master_run_o && !req_bad
    |=> done_o && result_o.read_byte_count == $past(node_resp_i.rcount))
    else $error("read count not returned on done");

  a_bad_slot: assert property (@(posedge clk_i iff ce_i) disable iff (sys_rst_i)
    rise && state_q == sdo_pkg::ST_IDLE && req_i.slot > sdo_pkg::SLOT_MAX
    |=> ##1 error_o && result_o.fail_code == sdo_pkg::CODE_PARAM)
    else $error("bad slot not refused");

  a_bad_wcount: assert property (@(posedge clk_i iff ce_i) disable iff (sys_rst_i)
    rise && state_q == sdo_pkg::ST_IDLE && req_i.service == sdo_pkg::SVC_WRITE && req_i.wcount > sdo_pkg::WCNT_MAX
    |=> ##1 error_o)
    else $error("bad write count not refused");

  a_forward_once: assert property (@(posedge clk_i iff ce_i) disable iff (sys_rst_i)
    node_req_valid_o && node_req_ready_i |=> !node_req_valid_o)
    else $error("request forwarded twice");

  a_error_clear: assert property (@(posedge clk_i iff ce_i) disable iff (sys_rst_i)
    error_o && !execute_i |=> !error_o)
    else $error("error stayed after execute low");

  a_done_hold: assert property (@(posedge clk_i iff ce_i) disable iff (sys_rst_i)
    done_o && execute_i |=> done_o)
    else $error("done dropped with execute high");

  a_abort_on_cmd: assert property (@(posedge clk_i iff ce_i) disable iff (sys_rst_i)
    busy_o && !req_bad && abort_cmd_i |=> aborted_o && !busy_o)
    else $error("abort command not honoured");
endmodule

// file: node_link_model.sv
/*
  Behavioural target node on the far side of the request link.
  Assumes the requesting block and this model share clk_i.
*/
`timescale 1ns/10ps
module node_link_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  input wire sdo_pkg::sdo_req_t req_i,
  input wire logic [2:0] delay_i,
  input wire logic fail_i,
  input wire logic mute_i,
  output logic req_ready_o,
  output logic resp_valid_o,
  output sdo_pkg::sdo_resp_t resp_o
);
  logic pend_q;
  logic [2:0] cnt_q;
  logic [31:0] noise_q;
  logic [127:0] fill;
  sdo_pkg::sdo_req_t cap_q;
  assign fill = {4{noise_q}};
  // Response lines change every cycle outside a response, so stale data never looks valid
  always_ff @(posedge clk_i) begin
    noise_q <= noise_q * 32'h0019660d + 32'h3c6ef35f;
    req_ready_o <= 1'b0;
    resp_valid_o <= 1'b0;
    resp_o <= fill[96:0];
    cnt_q <= cnt_q + 3'h1;
    if (req_valid_i && !req_ready_o && cnt_q == delay_i) begin
      req_ready_o <= 1'b1;
    end
    if (sys_rst_i) begin
      pend_q <= 1'b0;
      cnt_q <= 3'h0;
      noise_q <= 32'h00000001;
    end else if (req_valid_i && req_ready_o) begin
      pend_q <= 1'b1;
      cnt_q <= 3'h0;
      cap_q <= req_i;
    end else if (pend_q && !mute_i && cnt_q == delay_i) begin
      pend_q <= 1'b0;
      resp_valid_o <= 1'b1;
      resp_o.fail <= fail_i;
      resp_o.abort_reason <= cap_q.index;
      if (!fail_i) begin
        resp_o.rcount <= cap_q.wcount;
        resp_o.payload <= ~cap_q.payload;
      end
    end
  end
endmodule

// file: sdo_request_block_tb.sv
/*
  Self-checking bench of the SDO request handshake block.
  Assumes node_link_model on the link side and a 250 MHz clock.
*/
`timescale 1ns/10ps
module sdo_request_block_tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic execute_i = 1'b0;
  logic abort_cmd_i = 1'b0;
  sdo_pkg::sdo_req_t req_i = '0;
  logic [7:0] online = 8'hff, cfg_ok = 8'hff, reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, fail = 1'b0, mute = 1'b0, ce = 1'b1;
  logic [2:0] delay = 3'h0;
  logic done_o, busy_o, aborted_o, error_o, nvalid, nready, rvalid, run, irq_o;
  logic [7:0] exch;
  logic [31:0] reg_rdata_o;
  sdo_pkg::sdo_result_t result_o, last = '0;
  sdo_pkg::sdo_req_t nreq;
  sdo_pkg::sdo_resp_t nresp;
  int seed = 76788;
  int failures = 0, n_tests = 0, cyc = 0;
  bit kar = 1'b1;

  // Short timeout keeps the no-answer case brief
  sdo_request_block #(.RESP_TIMEOUT_CYC(64)) u_sdo_request_block (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .execute_i(execute_i), .req_i(req_i),
    .abort_cmd_i(abort_cmd_i), .done_o(done_o), .busy_o(busy_o), .aborted_o(aborted_o),
    .error_o(error_o), .result_o(result_o), .node_req_valid_o(nvalid), .node_req_ready_i(nready),
    .node_req_o(nreq), .node_resp_valid_i(rvalid), .node_resp_i(nresp), .slave_online_i(online),
    .slave_cfg_ok_i(cfg_ok), .master_run_o(run), .pdo_exchange_o(exch), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .irq_o(irq_o));
  node_link_model u_node_link_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(nvalid),
    .req_i(nreq), .delay_i(delay), .fail_i(fail), .mute_i(mute), .req_ready_o(nready),
    .resp_valid_o(rvalid), .resp_o(nresp));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      $display("CHECK FAILED at %0t: run too long", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [255:0] got, input logic [255:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  function automatic int unsigned rnd(input int unsigned n);
    return $unsigned($random(seed)) % n;
  endfunction

  function automatic sdo_pkg::sdo_req_t mk_req();
    sdo_pkg::sdo_req_t r;
    r.slot = 16'(rnd(12));
    r.node = 16'(rnd(127) + 1);
    r.service = 16'(rnd(2) + 1);
    r.index = 16'(rnd(65536));
    r.subindex = 16'(rnd(256));
    r.wcount = 16'(rnd(8) + 1);
    r.payload = {32'($random(seed)), 32'($random(seed))};
    return r;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp, "register read");
  endtask

  // k: 0 done, 1 error, 2 aborted; early drops execute before the result
  task automatic xfer(input sdo_pkg::sdo_req_t r, input int k, input logic [15:0] code, input bit early);
    int n;
    logic [2:0] f;
    f = (k == 0) ? 3'b100 : (k == 1) ? 3'b010 : 3'b001;
    @(posedge clk_i);
    execute_i <= 1'b1;
    req_i <= r;
    @(posedge clk_i);
    req_i <= ~r;
    abort_cmd_i <= (k == 2);
    #1 chk(busy_o, 1'b1, "busy after launch");
    @(posedge clk_i);
    abort_cmd_i <= 1'b0;
    execute_i <= !early;
    #1;
    if (k != 2 && code != sdo_pkg::CODE_PARAM && code != sdo_pkg::CODE_BUSY) begin
      chk({nvalid, nreq}, {1'b1, r}, "forwarded request");
    end
    if (early) begin
      @(posedge clk_i);
      execute_i <= 1'b1;
      @(posedge clk_i);
      execute_i <= 1'b0;
      #1;
    end
    n = 0;
    while (done_o !== 1'b1 && error_o !== 1'b1 && aborted_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk({done_o, error_o, aborted_o}, f, "result flags");
    chk(busy_o, 1'b0, "busy with result");
    if (k != 2) last.fail_code = code;
    if (k == 0 || code == sdo_pkg::CODE_REMOTE) begin
      last.abort_reason = r.index;
      kar = 1'b1;
    end else if (k == 1) begin
      kar = 1'b0;
    end
    if (k == 0) begin
      last.read_byte_count = r.wcount;
      last.read_payload = ~r.payload;
    end
    chk(result_o.fail_code, last.fail_code, "fail code");
    if (kar) chk(result_o.abort_reason, last.abort_reason, "abort reason");
    chk({result_o.read_byte_count, result_o.read_payload}, {last.read_byte_count, last.read_payload}, "read data");
    if (!early) begin
      @(posedge clk_i);
      execute_i <= 1'b0;
      #1 chk({done_o, error_o, aborted_o}, f, "flag held");
    end
    @(posedge clk_i);
    #1 chk({done_o, error_o, aborted_o}, 3'b000, "flag cleared");
  endtask

  initial begin
    sdo_pkg::sdo_req_t r;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(sdo_pkg::REG_IRQ_ENABLE, 32'h0);
    @(posedge clk_i);
    online <= 8'h07;
    wr(sdo_pkg::REG_CFG_MASK, 32'h0f);
    wr(sdo_pkg::REG_CTRL, 32'h3);
    repeat (8) @(posedge clk_i);
    #1 chk(run, 1'b0, "mandatory run held off");
    xfer(mk_req(), 1, sdo_pkg::CODE_BUSY, 1'b0);
    @(posedge clk_i);
    online <= 8'hff;
    repeat (8) @(posedge clk_i);
    #1 chk(run, 1'b1, "mandatory run");
    wr(sdo_pkg::REG_CTRL, 32'h2);
    @(posedge clk_i);
    online <= 8'hf5;
    cfg_ok <= 8'hdf;
    @(posedge clk_i);
    #1 chk({run, exch}, {1'b1, 8'h05}, "partial exchange");
    @(posedge clk_i);
    online <= 8'hff;
    cfg_ok <= 8'hff;
    $display("test config done");
    for (int i = 0; i < 12; i++) begin
      r = mk_req();
      if (i == 0) r = '{16'h000b, 16'h007f, sdo_pkg::SVC_WRITE, 16'hffff, 16'h00ff, 16'h0008, r.payload};
      if (i == 1) r = '{16'h0000, 16'h0001, sdo_pkg::SVC_WRITE, 16'h0000, 16'h0000, 16'h0001, r.payload};
      @(posedge clk_i);
      delay <= 3'(rnd(8));
      xfer(r, 0, sdo_pkg::CODE_OK, i[0]);
    end
    @(posedge clk_i);
    fail <= 1'b1;
    xfer(mk_req(), 1, sdo_pkg::CODE_REMOTE, 1'b1);
    @(posedge clk_i);
    fail <= 1'b0;
    mute <= 1'b1;
    xfer(mk_req(), 1, sdo_pkg::CODE_TIMEOUT, 1'b0);
    @(posedge clk_i);
    mute <= 1'b0;
    xfer(mk_req(), 2, sdo_pkg::CODE_IDLE, 1'b0);
    for (int i = 0; i < 7; i++) begin
      r = mk_req();
      r.service = sdo_pkg::SVC_WRITE;
      case (i)
        0: r.slot = 16'h000c;
        1: r.node = 16'h0000;
        2: r.node = 16'h0080;
        3: r.service = 16'h0000;
        4: r.service = 16'h0003;
        5: r.wcount = 16'h0000;
        default: r.wcount = 16'h0009;
      endcase
      xfer(r, 1, sdo_pkg::CODE_PARAM, 1'b0);
    end
    $display("test transfers done");
    // A write while the clock enable is low must leave the registers frozen
    ce <= 1'b0;
    wr(sdo_pkg::REG_IRQ_ENABLE, 32'hf);
    ce <= 1'b1;
    rd(sdo_pkg::REG_IRQ_ENABLE, 32'h0);
    rd(sdo_pkg::REG_IRQ_STATUS, 32'hf);
    chk(irq_o, 1'b0, "masked interrupt");
    wr(sdo_pkg::REG_IRQ_ENABLE, 32'h2);
    chk(irq_o, 1'b1, "enabled interrupt");
    rd(sdo_pkg::REG_IRQ_ENABLE, 32'h2);
    wr(sdo_pkg::REG_IRQ_CLEAR, 32'h2);
    chk(irq_o, 1'b0, "cleared interrupt");
    rd(sdo_pkg::REG_IRQ_STATUS, 32'hd);
    rd(sdo_pkg::REG_STATE, 32'h0f11);
    rd(8'h1c, 32'h0);
    $display("test registers done");
    end_of_test();
  end
endmodule
